// ==== hdl/teq_defines.svh ====
// Register offsets, field positions, reset values and counts for the touch queue
`ifndef TEQ_DEFINES_SVH
`define TEQ_DEFINES_SVH
`define TEQ_OFF_CTRL      8'h00
`define TEQ_OFF_STATUS    8'h04
`define TEQ_OFF_INJECT    8'h08
`define TEQ_OFF_QUEUE     8'h0c
`define TEQ_OFF_LEVEL     8'h10
`define TEQ_OFF_MENU      8'h14
`define TEQ_OFF_EVT_STAT  8'h18
`define TEQ_OFF_EVT_CLR   8'h1c
`define TEQ_OFF_EVT_EN    8'h20
`define TEQ_OFF_CMD       8'h24
`define TEQ_CTRL_PANEL_ON 0
`define TEQ_CTRL_TOUCH_EN 1
`define TEQ_CTRL_SRQ_EN   2
`define TEQ_CTRL_ID_EN    3
`define TEQ_CTRL_RPT_EN   4
`define TEQ_CTRL_RESET    5'h03
`define TEQ_CMD_CLEAR     0
`define TEQ_EVT_TOUCH     0
`define TEQ_EVT_RANGE     1
`define TEQ_EVT_OVERFLOW  2
`define TEQ_EVT_BITS      3
`define TEQ_DEPTH         20
`define TEQ_GRID_X_MAX    8'd11
`define TEQ_GRID_Y_MAX    8'd21
`define TEQ_BTN_COL       8'd11
`define TEQ_BTN_WAVE_ROW  8'd0
`define TEQ_BTN_TOUCH_ROW 8'd5
`define TEQ_BTN_CAL_ROW   8'd9
`define TEQ_MENU_NONE     4'h0
`define TEQ_EMPTY_WORD    32'hffffffff
`endif

// ==== hdl/teq_pkg.sv ====
// Types shared by the touch queue block
package teq_pkg;
    typedef logic [7:0] teq_coord_t;
    typedef enum logic [1:0] {TEQ_SRC_NONE, TEQ_SRC_PANEL, TEQ_SRC_REMOTE} teq_src_e;
endpackage

// ==== hdl/teq_touch_queue.sv ====
// Touch event queue with panel lockout gating, menu readback and event bits
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "teq_defines.svh"

// Function
// - Every touch's X,Y is queued in a store of twenty entries.
// - Panel and remote touches enter the queue identically.
// - A queue read returns oldest entry, x then y.
// - Empty queue reads give minus one for x and y.
// - Touch into a full queue drops oldest, appends newest.
// - Clear request empties the queue whatever its fill.
// - Buttons at column 11: row 0 waveform, 5 toggle, 9 calibration.
// - Injected touches never activate plug-in channel or probe-ident buttons.
// - Injected touches work despite lockout or touch toggle off.
// - Under lockout only enabled service icon and probe-ident buttons work.
// - Without lockout knob and buttons work; service icon and probe-ident need their enables; screen touches need toggle on.
// - Touch toggle blocks only screen touches, independent of lockout.
// - Lockout is inactive after power-up.
// - Lockout can be set and read back remotely.
// - Same major menu selected twice in a row reads blank.
// - Out-of-grid injected touch raises range error, not queued.
// - Touch report mask enabled raises an event per touch.
module teq_touch_queue
    import teq_pkg::*;
#(
    parameter int DEPTH = `TEQ_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Physical panel, asynchronous pins
    input wire logic pin_touch,
    input wire logic [7:0] pin_x,
    input wire logic [7:0] pin_y,
    input wire logic pin_knob,
    input wire logic pin_srq_icon,
    input wire logic pin_probe_id,
    // Gated local controls
    output logic knob_act,
    output logic srq_icon_act,
    output logic probe_id_act,
    output logic [3:0] menu_sel,
    // Interrupt
    output logic irq
);
    // Level and pointers are sized from DEPTH; refuse sizes they cannot count
    if (DEPTH < 2 || DEPTH > 255) begin : g_depth_check
        $error("DEPTH out of range");
    end

    localparam int PW = $clog2(DEPTH);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree
    logic [19:0] s1, s2, s3;
    logic [19:0] stable;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1 <= 20'h00000;
            s2 <= 20'h00000;
            s3 <= 20'h00000;
            stable <= 20'h00000;
        end else begin
            s1 <= {pin_probe_id, pin_srq_icon, pin_knob, pin_touch, pin_x, pin_y};
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < 20; i++) begin
                if (s2[i] == s3[i]) stable[i] <= s3[i];
            end
        end
    end
    logic touch_q, knob_q, srq_q, id_q;
    logic touch_prev, knob_prev, srq_prev, id_prev;
    assign touch_q = stable[16];
    assign knob_q = stable[17];
    assign srq_q = stable[18];
    assign id_q = stable[19];
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            touch_prev <= 1'b0;
            knob_prev <= 1'b0;
            srq_prev <= 1'b0;
            id_prev <= 1'b0;
        end else begin
            touch_prev <= touch_q;
            knob_prev <= knob_q;
            srq_prev <= srq_q;
            id_prev <= id_q;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic [4:0] ctrl;
    logic [`TEQ_EVT_BITS-1:0] evt_stat, evt_en;
    logic bus_req, wr_req, rd_req;
    // Ack high blocks a second take of the same held request
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_req = bus_req && wb_we_i && wb_sel_i[0];
    assign rd_req = bus_req && !wb_we_i;
    logic panel_on, touch_en;
    assign panel_on = ctrl[`TEQ_CTRL_PANEL_ON];
    assign touch_en = ctrl[`TEQ_CTRL_TOUCH_EN];

    // Lockout released at reset; toggle button flips touch enable
    logic toggle_hit;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl <= `TEQ_CTRL_RESET;
        end else if (toggle_hit) begin
            ctrl <= ctrl ^ (5'h01 << `TEQ_CTRL_TOUCH_EN);
        end else if (wr_req && wb_adr_i == `TEQ_OFF_CTRL) begin
            ctrl <= wb_dat_i[4:0];
        end
    end

    // ----------------------------------------------------------------
    // Touch sources
    // ----------------------------------------------------------------
    teq_coord_t in_x, in_y;
    teq_src_e src;
    logic inj_wr, inj_ok;
    assign inj_wr = wr_req && wb_adr_i == `TEQ_OFF_INJECT;
    // Remote grid check; plug-in buttons lie outside the grid
    assign inj_ok = wb_dat_i[7:0] <= `TEQ_GRID_X_MAX
        && wb_dat_i[15:8] <= `TEQ_GRID_Y_MAX;
    logic panel_touch, btn_press;
    // Column 11 is the hard button column; the toggle must not lock out its own button
    assign btn_press = stable[15:8] == `TEQ_BTN_COL;
    // Screen touch needs toggle on and no lockout; buttons only need no lockout
    assign panel_touch = touch_q && !touch_prev && panel_on
        && (touch_en || btn_press);

    // Remote injection wins the cycle; ignores lockout and toggle
    always_comb begin
        src = TEQ_SRC_NONE;
        in_x = stable[15:8];
        in_y = stable[7:0];
        if (inj_wr && inj_ok) begin
            src = TEQ_SRC_REMOTE;
            in_x = wb_dat_i[7:0];
            in_y = wb_dat_i[15:8];
        end else if (panel_touch) begin
            src = TEQ_SRC_PANEL;
        end
    end
    logic push;
    assign push = src != TEQ_SRC_NONE;

    // Button decode at column 11
    logic is_btn;
    assign is_btn = push && in_x == `TEQ_BTN_COL;
    assign toggle_hit = is_btn && in_y == `TEQ_BTN_TOUCH_ROW;

    // ----------------------------------------------------------------
    // Queue storage
    // ----------------------------------------------------------------
    logic [15:0] mem [DEPTH];
    logic [PW-1:0] rd_ptr, wr_ptr;
    logic [PW:0] level;
    logic clr_req, pop, full;
    assign clr_req = wr_req && wb_adr_i == `TEQ_OFF_CMD && wb_dat_i[`TEQ_CMD_CLEAR];
    // A read pops only when something is held; empty reads return all ones
    assign pop = rd_req && wb_adr_i == `TEQ_OFF_QUEUE && level != '0;
    assign full = level == (PW+1)'(DEPTH);

    function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
        inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Storage has no reset; level alone says which slots hold touches
    always_ff @(posedge clk_sys) begin
        if (push) mem[clr_req ? '0 : wr_ptr] <= {in_y, in_x};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            level <= '0;
        end else if (clr_req) begin
            // Clear first, then the same-cycle touch lands in slot zero
            rd_ptr <= '0;
            wr_ptr <= push ? PW'(1) : '0;
            level <= push ? (PW+1)'(1) : '0;
        end else begin
            if (push) wr_ptr <= inc(wr_ptr);
            if (push && full) begin
                rd_ptr <= inc(rd_ptr);
            end else if (pop) begin
                rd_ptr <= inc(rd_ptr);
            end
            if (push && !full && !pop) level <= level + 1'b1;
            else if (pop && !push) level <= level - 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Active major menu
    // ----------------------------------------------------------------
    // Rows 0..4 of the button column select a menu; repeat gives blank
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            menu_sel <= `TEQ_MENU_NONE;
        end else if (is_btn && in_y <= 8'd4) begin
            if (menu_sel == 4'(in_y + 8'd1)) menu_sel <= `TEQ_MENU_NONE;
            else menu_sel <= 4'(in_y + 8'd1);
        end
    end

    // ----------------------------------------------------------------
    // Local control gating
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            knob_act <= 1'b0;
            srq_icon_act <= 1'b0;
            probe_id_act <= 1'b0;
        end else begin
            knob_act <= knob_q && !knob_prev && panel_on;
            srq_icon_act <= srq_q && !srq_prev && ctrl[`TEQ_CTRL_SRQ_EN];
            probe_id_act <= id_q && !id_prev && ctrl[`TEQ_CTRL_ID_EN];
        end
    end

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------
    logic [`TEQ_EVT_BITS-1:0] evt_set;
    always_comb begin
        evt_set = '0;
        evt_set[`TEQ_EVT_TOUCH] = push && ctrl[`TEQ_CTRL_RPT_EN];
        evt_set[`TEQ_EVT_RANGE] = inj_wr && !inj_ok;
        evt_set[`TEQ_EVT_OVERFLOW] = push && full && !clr_req;
    end
    // Next status and enable; set beats a same-cycle clear so no event is lost
    logic [`TEQ_EVT_BITS-1:0] next_evt_stat, next_evt_en;
    always_comb begin
        next_evt_stat = evt_stat | evt_set;
        next_evt_en = evt_en;
        if (wr_req && wb_adr_i == `TEQ_OFF_EVT_CLR) begin
            next_evt_stat = (evt_stat & ~wb_dat_i[`TEQ_EVT_BITS-1:0]) | evt_set;
        end
        if (wr_req && wb_adr_i == `TEQ_OFF_EVT_EN) begin
            next_evt_en = wb_dat_i[`TEQ_EVT_BITS-1:0];
        end
    end
    // Irq follows the next values, so it drops at the same edge as the clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            evt_stat <= '0;
            evt_en <= '0;
            irq <= 1'b0;
        end else begin
            evt_stat <= next_evt_stat;
            evt_en <= next_evt_en;
            irq <= |(next_evt_stat & next_evt_en);
        end
    end

    // ----------------------------------------------------------------
    // Bus answer
    // ----------------------------------------------------------------
    logic [31:0] next_dat;
    always_comb begin
        case (wb_adr_i)
            `TEQ_OFF_CTRL: next_dat = {27'h0, ctrl};
            `TEQ_OFF_STATUS: next_dat = {30'h0, full, level == '0};
            `TEQ_OFF_QUEUE: next_dat = (level == '0) ? `TEQ_EMPTY_WORD
                : {8'h00, mem[rd_ptr][15:8], 8'h00, mem[rd_ptr][7:0]};
            `TEQ_OFF_LEVEL: next_dat = {24'h0, 8'(level)};
            `TEQ_OFF_MENU: next_dat = {28'h0, menu_sel};
            `TEQ_OFF_EVT_STAT: next_dat = {29'h0, evt_stat};
            `TEQ_OFF_EVT_EN: next_dat = {29'h0, evt_en};
            default: next_dat = 32'h00000000;
        endcase
    end
    // One wait state: ack the cycle after the request
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (rd_req) wb_dat_o <= next_dat;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Queue level, overflow, pops, clearing and empty reads
    a_level_bound: assert property (@(posedge clk_sys) disable iff (rst)
        level <= (PW+1)'(DEPTH))
        else $error("queue level above depth");
    a_overflow_keeps: assert property (@(posedge clk_sys) disable iff (rst)
        push && full && !clr_req |=> full)
        else $error("overflow lost level");
    a_overflow_event: assert property (@(posedge clk_sys) disable iff (rst)
        push && full && !clr_req |=> evt_stat[`TEQ_EVT_OVERFLOW])
        else $error("overflow event missing");
    a_pop_level: assert property (@(posedge clk_sys) disable iff (rst)
        pop && !push && !clr_req |=> level == $past(level) - 1)
        else $error("read did not pop one entry");
    a_clear_empty: assert property (@(posedge clk_sys) disable iff (rst)
        clr_req && !push |=> level == '0)
        else $error("clear left entries");
    a_clear_ptrs: assert property (@(posedge clk_sys) disable iff (rst)
        clr_req |=> rd_ptr == '0)
        else $error("clear left read pointer");
    a_clear_touch: assert property (@(posedge clk_sys) disable iff (rst)
        clr_req && push |=> level == 1)
        else $error("clear with touch wrong");
    a_empty_read: assert property (@(posedge clk_sys) disable iff (rst)
        rd_req && wb_adr_i == `TEQ_OFF_QUEUE && level == '0 |=> wb_dat_o == 32'hffffffff)
        else $error("empty read not minus one");
    // Remote injection, range errors and the toggle button
    a_range_reject: assert property (@(posedge clk_sys) disable iff (rst)
        inj_wr && !inj_ok |=> evt_stat[`TEQ_EVT_RANGE] && $stable(level))
        else $error("bad injection queued");
    a_inject_lock: assert property (@(posedge clk_sys) disable iff (rst)
        inj_wr && inj_ok && !clr_req && !full |=> level == $past(level) + 1)
        else $error("injection not queued");
    a_toggle_flip: assert property (@(posedge clk_sys) disable iff (rst)
        toggle_hit |=> touch_en != $past(touch_en))
        else $error("toggle button did not flip");
    // Panel gating and masks
    a_lockout_knob: assert property (@(posedge clk_sys) disable iff (rst)
        !panel_on |=> !knob_act)
        else $error("knob acted under lockout");
    a_knob_open: assert property (@(posedge clk_sys) disable iff (rst)
        panel_on && knob_q && !knob_prev |=> knob_act)
        else $error("knob ignored without lockout");
    a_lock_touch: assert property (@(posedge clk_sys) disable iff (rst)
        !panel_on && !(inj_wr && inj_ok) |-> !push)
        else $error("panel touch queued under lockout");
    a_touch_gate: assert property (@(posedge clk_sys) disable iff (rst)
        !touch_en && !(inj_wr && inj_ok) && !btn_press |-> !push)
        else $error("screen touch passed closed toggle");
    a_srq_mask: assert property (@(posedge clk_sys) disable iff (rst)
        !ctrl[`TEQ_CTRL_SRQ_EN] |=> !srq_icon_act)
        else $error("service icon acted while masked");
    a_probe_mask: assert property (@(posedge clk_sys) disable iff (rst)
        !ctrl[`TEQ_CTRL_ID_EN] |=> !probe_id_act)
        else $error("probe ident acted while masked");
    // Menu, events and bus answer
    a_menu_blank: assert property (@(posedge clk_sys) disable iff (rst)
        is_btn && in_y <= 8'd4 && menu_sel == 4'(in_y + 8'd1) |=> menu_sel == `TEQ_MENU_NONE)
        else $error("repeated menu not blank");
    a_touch_event: assert property (@(posedge clk_sys) disable iff (rst)
        push && ctrl[`TEQ_CTRL_RPT_EN] |=> evt_stat[`TEQ_EVT_TOUCH])
        else $error("touch event missing");
    a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
        irq == |(evt_stat & evt_en))
        else $error("irq does not follow enabled status");
    a_ack_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule // teq_touch_queue
`default_nettype wire

// ==== verif/teq_host_model.sv ====
// Remote host model: Wishbone classic master that issues register commands
`timescale 1ns/1ns
`default_nettype none
module teq_host_model (
    // Clock
    input wire logic clk_sys,
    // Wishbone master
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [7:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i
);
    // ----------------------------------------
    // Bus cycle
    // ----------------------------------------
    // Idle bus at time zero
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end
    // One classic cycle; held until ack is seen high at a rising edge
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        output logic [31:0] rdat);
        @(posedge clk_sys);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_sel_o <= 4'hf;
        wb_dat_o <= dat;
        do @(posedge clk_sys); while (wb_ack_i !== 1'b1);
        rdat = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        // Stale write data is inverted so it never looks like a fresh value
        wb_dat_o <= ~dat;
    endtask
endmodule // teq_host_model
`default_nettype wire

// ==== verif/test_teq_touch_queue.sv ====
// Self-checking bench for the touch event queue
`timescale 1ns/1ns
`default_nettype none
`include "teq_defines.svh"
module test_teq_touch_queue
    import teq_pkg::*;
;
    logic clk_sys, rst, cyc, stb, we, ack, touch, knob_act, srq_act, probe_act, irq;
    logic [7:0] adr, px, py;
    logic [3:0] sel, menu_sel;
    logic [31:0] wdat, rdat;
    logic [2:0] ctl_pins;
    int errors = 0, n_checks = 0, n_knob = 0, n_srq = 0, n_probe = 0;
    teq_touch_queue teq_touch_queue_inst (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .pin_touch(touch), .pin_x(px), .pin_y(py),
        .pin_knob(ctl_pins[0]), .pin_srq_icon(ctl_pins[1]), .pin_probe_id(ctl_pins[2]),
        .knob_act(knob_act), .srq_icon_act(srq_act), .probe_id_act(probe_act),
        .menu_sel(menu_sel), .irq(irq));
    teq_host_model teq_host_model_inst (.clk_sys(clk_sys), .wb_cyc_o(cyc), .wb_stb_o(stb),
        .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat),
        .wb_ack_i(ack));
    // ----------------------------------------
    // Clock, pulse counters, helpers
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Gated controls answer with one-cycle pulses, so count them
    always @(posedge clk_sys) begin
        if (knob_act === 1'b1) n_knob <= n_knob + 1;
        if (srq_act === 1'b1) n_srq <= n_srq + 1;
        if (probe_act === 1'b1) n_probe <= n_probe + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        teq_host_model_inst.xfer(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        teq_host_model_inst.xfer(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    task automatic inj(input logic [7:0] x, input logic [7:0] y);
        wr(`TEQ_OFF_INJECT, {16'h0, y, x});
    endtask
    // Coordinates settle well before the edge; the pins pass a synchroniser
    task automatic panel(input logic [7:0] x, input logic [7:0] y);
        px <= x;
        py <= y;
        repeat (6) @(posedge clk_sys);
        touch <= 1'b1;
        repeat (6) @(posedge clk_sys);
        touch <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic ctl(input logic [2:0] m);
        ctl_pins <= m;
        repeat (6) @(posedge clk_sys);
        ctl_pins <= 3'b000;
        repeat (8) @(posedge clk_sys);
    endtask
    function automatic logic [31:0] qw(input int x, input int y);
        return {8'h00, 8'(y), 8'h00, 8'(x)};
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdc(`TEQ_OFF_CTRL, 32'h3);
        rdc(`TEQ_OFF_QUEUE, 32'hffffffff);
        rdc(8'h3c, 32'h0);
        rdc(`TEQ_OFF_STATUS, 32'h1);
        chk({27'h0, menu_sel, irq}, 32'h0);
    endtask
    // One past full: oldest entry must go, order otherwise kept
    task automatic t_fill();
        for (int i = 0; i <= 20; i++) inj(8'(i % 12), 8'(i));
        rdc(`TEQ_OFF_LEVEL, 32'd20);
        rdc(`TEQ_OFF_STATUS, 32'h2);
        for (int i = 1; i <= 20; i++) rdc(`TEQ_OFF_QUEUE, qw(i % 12, i));
        rdc(`TEQ_OFF_QUEUE, 32'hffffffff);
    endtask
    task automatic t_panel();
        panel(8'd3, 8'd4);
        ctl(3'b001);
        chk(n_knob, 1);
        wr(`TEQ_OFF_CTRL, 32'h1);
        panel(8'd5, 8'd6);
        ctl(3'b001);
        chk(n_knob, 2);
        // The toggle button itself still works while screen touches are off
        panel(8'd11, 8'd5);
        rdc(`TEQ_OFF_CTRL, 32'h3);
        wr(`TEQ_OFF_CTRL, 32'h2);
        panel(8'd7, 8'd8);
        ctl(3'b111);
        chk({n_knob[15:0], n_srq[7:0], n_probe[7:0]}, 32'h00020000);
        rdc(`TEQ_OFF_CTRL, 32'h2);
        wr(`TEQ_OFF_CTRL, 32'h0);
        inj(8'd9, 8'd10);
        rdc(`TEQ_OFF_LEVEL, 32'd3);
        rdc(`TEQ_OFF_QUEUE, qw(3, 4));
        rdc(`TEQ_OFF_QUEUE, qw(11, 5));
        rdc(`TEQ_OFF_QUEUE, qw(9, 10));
    endtask
    task automatic t_masks();
        wr(`TEQ_OFF_CTRL, 32'h4);
        ctl(3'b110);
        chk({n_srq[15:0], n_probe[15:0]}, 32'h00010000);
        wr(`TEQ_OFF_CTRL, 32'h8);
        ctl(3'b110);
        chk({n_srq[15:0], n_probe[15:0]}, 32'h00010001);
        wr(`TEQ_OFF_CTRL, 32'h3);
    endtask
    task automatic t_clear();
        for (int i = 0; i < 3; i++) inj(8'd1, 8'(i));
        wr(`TEQ_OFF_CMD, 32'h1);
        rdc(`TEQ_OFF_LEVEL, 32'd0);
        rdc(`TEQ_OFF_QUEUE, 32'hffffffff);
        // Panel touch lands at the clear's edge: old entry goes, touch stays
        inj(8'd1, 8'd3);
        px <= 8'd6;
        py <= 8'd7;
        repeat (6) @(posedge clk_sys);
        touch <= 1'b1;
        repeat (3) @(posedge clk_sys);
        wr(`TEQ_OFF_CMD, 32'h1);
        touch <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rdc(`TEQ_OFF_LEVEL, 32'd1);
        rdc(`TEQ_OFF_QUEUE, qw(6, 7));
    endtask
    // Grid edges: 11,21 fits, 12,0 and 0,22 do not
    task automatic t_range();
        rdc(`TEQ_OFF_EVT_STAT, 32'h4);
        wr(`TEQ_OFF_EVT_CLR, 32'h7);
        wr(`TEQ_OFF_EVT_EN, 32'h2);
        inj(8'd12, 8'd0);
        inj(8'd0, 8'd22);
        inj(8'd11, 8'd21);
        rdc(`TEQ_OFF_LEVEL, 32'd1);
        rdc(`TEQ_OFF_EVT_STAT, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(`TEQ_OFF_EVT_EN, 32'h0);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(`TEQ_OFF_EVT_EN, 32'h2);
        wr(`TEQ_OFF_EVT_CLR, 32'h2);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        rdc(`TEQ_OFF_EVT_STAT, 32'h0);
        wr(`TEQ_OFF_CTRL, 32'h13);
        panel(8'd1, 8'd2);
        rdc(`TEQ_OFF_EVT_STAT, 32'h1);
        wr(`TEQ_OFF_CTRL, 32'h3);
    endtask
    task automatic t_menu();
        inj(`TEQ_BTN_COL, `TEQ_BTN_WAVE_ROW);
        repeat (3) @(posedge clk_sys);
        chk({28'h0, menu_sel}, 32'h1);
        inj(`TEQ_BTN_COL, `TEQ_BTN_WAVE_ROW);
        repeat (3) @(posedge clk_sys);
        chk({28'h0, menu_sel}, 32'h0);
        inj(`TEQ_BTN_COL, 8'd1);
        repeat (3) @(posedge clk_sys);
        chk({28'h0, menu_sel}, 32'h2);
        inj(`TEQ_BTN_COL, `TEQ_BTN_TOUCH_ROW);
        rdc(`TEQ_OFF_CTRL, 32'h1);
        inj(`TEQ_BTN_COL, `TEQ_BTN_TOUCH_ROW);
        rdc(`TEQ_OFF_CTRL, 32'h3);
        wr(`TEQ_OFF_CMD, 32'h1);
    endtask
    // Mid-run reset must release the lockout and empty the queue again
    task automatic t_rerst();
        wr(`TEQ_OFF_CTRL, 32'h0);
        inj(8'd2, 8'd3);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(`TEQ_OFF_CTRL, 32'h3);
        rdc(`TEQ_OFF_LEVEL, 32'd0);
        chk({27'h0, menu_sel, irq}, 32'h0);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        touch = 1'b0;
        px = 8'h00;
        py = 8'h00;
        ctl_pins = 3'b000;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_fill();
        t_panel();
        t_masks();
        t_clear();
        t_range();
        t_menu();
        t_rerst();
        close_out();
    end
    // Whole run needs under a thousand cycles; this margin only catches a hang
    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        close_out();
    end
endmodule // test_teq_touch_queue
`default_nettype wire
